// ---- include/dtha_cfg.svh ----
// constants for the drive table, homing and auxiliary position block
`ifndef DTHA_CFG_SVH
`define DTHA_CFG_SVH
`define DTHA_TICK_NS         6144000
`define DTHA_CLK_NS          8
`define DTHA_HOLD_MS         150
`define DTHA_TBL_DEPTH       256
`define DTHA_TBL_KEEP        64
`define DTHA_DIRECT_SPAN     128
`define DTHA_MODE_LEN        18
`define DTHA_VSPEED_MAX      3500
`define DTHA_QUAD_STEPS      1024
`define DTHA_A_CTRL          8'h00
`define DTHA_A_STAT          8'h04
`define DTHA_A_PTR           8'h08
`define DTHA_A_VAL           8'h0C
`define DTHA_A_NEXT          8'h10
`define DTHA_A_THA           8'h14
`define DTHA_A_THB           8'h18
`define DTHA_A_MPOS          8'h1C
`define DTHA_A_PREF          8'h20
`define DTHA_A_CAPT          8'h24
`define DTHA_A_HSPD          8'h28
`define DTHA_A_SPSET         8'h2C
`define DTHA_A_PRESET        8'h30
`define DTHA_A_VSPD          8'h34
`define DTHA_A_OPMODE        8'h38
`define DTHA_A_MPAR          8'h3C
`define DTHA_A_DIRECT        8'h80
`define DTHA_B_SRC_A         0
`define DTHA_B_SRC_B         1
`define DTHA_B_HOME1         2
`define DTHA_B_HOME2         3
`define DTHA_B_MLOAD         4
`define DTHA_B_VAX           5
`define DTHA_B_CAPCLR        6
`define DTHA_B_LOOPEN        7
`define DTHA_B_FLAG_A        0
`define DTHA_B_FLAG_B        1
`define DTHA_B_CAPF          2
`define DTHA_CFG_VAX         3'h4
`endif

// ---- include/dtha_pkg.sv ----
// types for the drive table, homing and auxiliary position block
package dtha_pkg;
  typedef enum logic [2:0] {
    DTHA_H_IDLE    = 3'b000,
    DTHA_H_BACKOFF = 3'b001,
    DTHA_H_SEEK    = 3'b010,
    DTHA_H_HOLD    = 3'b011,
    DTHA_H_DONE    = 3'b100
  } dtha_home_t;
endpackage

// ---- design/dtha_quad.sv ----
// virtual encoder quadrature generator
`timescale 1ns/1ps
`default_nettype none
`include "dtha_cfg.svh"
module dtha_quad #(
  parameter int CLK_NS = `DTHA_CLK_NS
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               enable,
  input  wire logic signed [15:0] speed,
  output logic                    phase_a,
  output logic                    phase_b
);
  // steps per second = rpm*1024/60; accumulate rpm*1024 per clock, wrap at 60*1e9/CLK_NS: phase acc
  localparam longint WRAP = 64'd60 * 64'd1000000000 / CLK_NS;
  initial if (CLK_NS < 1) $error("clock period must be positive");
  logic signed [15:0] lim;
  logic        [15:0] mag;
  logic        [47:0] acc;
  logic        [1:0]  pos;
  wire         [47:0] next_acc = acc + 48'(mag) * 48'(`DTHA_QUAD_STEPS);
  wire                step     = next_acc >= 48'(WRAP);
  localparam logic signed [15:0] VMAX = 16'(`DTHA_VSPEED_MAX);
  assign lim = (speed > VMAX) ? VMAX : (speed < -VMAX) ? -VMAX : speed;
  assign mag = lim[15] ? 16'(-lim) : lim;
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      acc <= '0;
      pos <= 2'h0;
    end else begin
      acc <= step ? next_acc - 48'(WRAP) : next_acc;
      if (step)
        pos <= lim[15] ? pos - 2'h1 : pos + 2'h1;
    end
  end
  // gray walk, no index channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_a <= 1'b0;
      phase_b <= 1'b0;
    end else begin
      phase_a <= pos[1];
      phase_b <= pos[1] ^ pos[0];
    end
  end
endmodule
`default_nettype wire

// ---- design/dtha_top.sv ----
// table, compare, capture, homing, mode load and virtual axis
`timescale 1ns/1ps
`default_nettype none
`include "dtha_cfg.svh"
module dtha_top #(
  parameter int TICK_CYCLES = (`DTHA_TICK_NS + `DTHA_CLK_NS - 1) / `DTHA_CLK_NS,
  parameter int HOLD_TICKS  = (`DTHA_HOLD_MS * 1000000 + `DTHA_TICK_NS - 1) / `DTHA_TICK_NS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        capture_input,
  input  wire logic        homing_sensor,
  input  wire logic [31:0] motor_position_in,
  input  wire logic [2:0]  axis_config,
  output logic             position_load,
  output logic [31:0]      position_load_value,
  output logic             encoder_emulation_a,
  output logic             encoder_emulation_b
);
  initial if (TICK_CYCLES < 2 || HOLD_TICKS < 1) $error("tick or hold count too small");

  // ************************************************
  // state
  // ************************************************
  logic [15:0] tbl [`DTHA_TBL_DEPTH];
  logic [7:0]  table_pointer, ptr_seen;
  logic [15:0] table_value;
  logic        ptr_dirty, val_dirty;
  logic [31:0] compare_threshold_a, compare_threshold_b, position_reference;
  logic [31:0] captured_position, home_preset_value;
  logic [15:0] homing_speed, speed_setpoint, virtual_axis_speed, operating_mode_select;
  logic [15:0] mode_par [`DTHA_MODE_LEN-1];
  logic        compare_a_source_sel, compare_b_source_sel, compare_a_flag, compare_b_flag;
  logic        capture_event_flag, homing_type1_cmd, homing_type2_cmd, mode_load_cmd;
  logic        virtual_axis_enable, position_loop_enable;
  logic [31:0] tick_cnt;
  logic [15:0] hold_cnt;
  logic [4:0]  ml_idx;
  logic [1:0]  cap_sync, home_sync;
  logic        cap_prev, home_prev, home_type2, clear_busy;
  dtha_pkg::dtha_home_t hstate;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data;
  logic        aw_have, w_have, rd_pend;

  // ************************************************
  // decode
  // ************************************************
  wire tick      = tick_cnt == 32'(TICK_CYCLES - 1);
  wire do_write  = aw_have && w_have && !s_axi_bvalid;
  wire wr_direct = aw_addr[7];
  wire [6:0] wr_dix = aw_addr[6:0] >> 2;
  wire [7:0] r_dix  = {1'b0, ar_addr[6:0] >> 2};
  wire [7:0] nxt_ix = table_pointer + 8'h01;
  wire [7:0] ml_ix  = table_pointer + 8'(ml_idx);
  wire [31:0] mpos  = motor_position_in;
  wire cap_rise     = cap_sync[1] & ~cap_prev;
  wire home_rise    = home_sync[1] & ~home_prev;
  wire home_cmd     = homing_type1_cmd | homing_type2_cmd;
  wire home_end     = hstate == dtha_pkg::DTHA_H_HOLD && hold_cnt == 16'(HOLD_TICKS) && tick;
  wire ml_end       = mode_load_cmd && ml_idx == 5'(`DTHA_MODE_LEN - 1);
  wire vax_ok       = virtual_axis_enable && axis_config == `DTHA_CFG_VAX;
  wire wr_ctrl      = do_write && aw_addr == `DTHA_A_CTRL;
  wire wr_ptr       = do_write && aw_addr == `DTHA_A_PTR;
  wire wr_val       = do_write && aw_addr == `DTHA_A_VAL;
  wire [31:0] ctrl_rd = {24'h0, position_loop_enable, 1'b0, virtual_axis_enable, mode_load_cmd,
                         homing_type2_cmd, homing_type1_cmd, compare_b_source_sel, compare_a_source_sel};
  wire [31:0] rd_mux =
    ar_addr[7]                ? {16'h0, tbl[r_dix]} :
    ar_addr == `DTHA_A_CTRL   ? ctrl_rd :
    ar_addr == `DTHA_A_STAT   ? {29'h0, capture_event_flag, compare_b_flag, compare_a_flag} :
    ar_addr == `DTHA_A_PTR    ? {24'h0, table_pointer} :
    ar_addr == `DTHA_A_VAL    ? {16'h0, table_value} :
    ar_addr == `DTHA_A_NEXT   ? {16'h0, tbl[nxt_ix]} :
    ar_addr == `DTHA_A_THA    ? compare_threshold_a :
    ar_addr == `DTHA_A_THB    ? compare_threshold_b :
    ar_addr == `DTHA_A_MPOS   ? mpos :
    ar_addr == `DTHA_A_PREF   ? position_reference :
    ar_addr == `DTHA_A_CAPT   ? captured_position :
    ar_addr == `DTHA_A_HSPD   ? {16'h0, homing_speed} :
    ar_addr == `DTHA_A_SPSET  ? {16'h0, speed_setpoint} :
    ar_addr == `DTHA_A_PRESET ? home_preset_value :
    ar_addr == `DTHA_A_VSPD   ? {16'h0, virtual_axis_speed} :
    ar_addr == `DTHA_A_OPMODE ? {16'h0, operating_mode_select} :
    ar_addr == `DTHA_A_MPAR   ? {16'h0, mode_par[0]} : 32'h0;
  wire rd_ok = ar_addr[7] || ar_addr <= `DTHA_A_MPAR;
  wire wr_ok = wr_direct || aw_addr <= `DTHA_A_MPAR;

  // ************************************************
  // axi4-lite slave
  // ************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_have, w_have, s_axi_bvalid, s_axi_rvalid, rd_pend} <= 5'h00;
      {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h7;
      s_axi_bresp <= 2'h0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
      aw_addr <= 8'h00;
      ar_addr <= 8'h00;
      w_data  <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        {aw_have, w_have} <= 2'h0;
        {s_axi_awready, s_axi_wready} <= 2'h3;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rd_pend <= 1'b1;
      end
      // mux reads the latched address, so valid rises one cycle later together with data
      if (rd_pend) begin
        rd_pend      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ************************************************
  // tick, input sampling
  // ************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt  <= 32'h0;
      cap_sync  <= 2'h0;
      home_sync <= 2'h0;
      cap_prev  <= 1'b0;
      home_prev <= 1'b0;
    end else begin
      tick_cnt  <= tick ? 32'h0 : tick_cnt + 32'h1;
      cap_sync  <= {cap_sync[0], capture_input};
      home_sync <= {home_sync[0], homing_sensor};
      cap_prev  <= cap_sync[1];
      if (tick)
        home_prev <= home_sync[1];
    end
  end

  // ************************************************
  // table and mode load
  // ************************************************
  // reset clears the volatile part a word per cycle; keeping 0..63 models retention
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_busy <= 1'b1;
      ptr_seen   <= 8'(`DTHA_TBL_KEEP);
      table_pointer <= 8'h00;
      table_value   <= 16'h0;
      {ptr_dirty, val_dirty} <= 2'h0;
    end else if (clear_busy) begin
      tbl[ptr_seen] <= 16'h0;
      ptr_seen <= ptr_seen + 8'h01;
      if (ptr_seen == 8'hFF) begin
        clear_busy <= 1'b0;
        ptr_seen   <= 8'h00;
      end
    end else begin
      if (wr_ptr) begin
        table_pointer <= w_data[7:0];
        ptr_dirty <= 1'b1;
      end
      if (wr_val) begin
        table_value <= w_data[15:0];
        val_dirty <= 1'b1;
      end
      // pointer path is assigned later, so it wins a same-entry clash
      if (do_write && wr_direct)
        tbl[{1'b0, wr_dix}] <= w_data[15:0];
      if (tick) begin
        // a write landing on the tick edge stays pending for the next tick
        ptr_dirty <= wr_ptr;
        val_dirty <= wr_val;
        if (val_dirty)
          tbl[table_pointer] <= table_value;
        else if (ptr_dirty && !wr_val)
          table_value <= tbl[table_pointer];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_load_cmd <= 1'b0;
      ml_idx <= 5'h0;
      operating_mode_select <= 16'h0;
    end else begin
      if (wr_ctrl)
        mode_load_cmd <= w_data[`DTHA_B_MLOAD] | mode_load_cmd;
      if (mode_load_cmd && tick_cnt[0]) begin
        if (ml_idx == 5'h0)
          operating_mode_select <= tbl[ml_ix];
        else
          mode_par[ml_idx - 5'h1] <= tbl[ml_ix];
        ml_idx <= ml_idx + 5'h1;
        if (ml_end) begin
          mode_load_cmd <= 1'b0;
          ml_idx <= 5'h0;
        end
      end
    end
  end

  // ************************************************
  // control, compare, capture, homing
  // ************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {compare_a_source_sel, compare_b_source_sel, virtual_axis_enable} <= 3'h0;
      {compare_a_flag, compare_b_flag, capture_event_flag} <= 3'h0;
      {homing_type1_cmd, homing_type2_cmd, position_loop_enable, home_type2} <= 4'h0;
      {compare_threshold_a, compare_threshold_b, position_reference} <= 96'h0;
      {captured_position, home_preset_value} <= 64'h0;
      {homing_speed, speed_setpoint, virtual_axis_speed} <= 48'h0;
      hstate <= dtha_pkg::DTHA_H_IDLE;
      hold_cnt <= 16'h0;
      position_load <= 1'b0;
      position_load_value <= 32'h0;
    end else begin
      position_load <= 1'b0;
      if (wr_ctrl) begin
        compare_a_source_sel <= w_data[`DTHA_B_SRC_A];
        compare_b_source_sel <= w_data[`DTHA_B_SRC_B];
        homing_type1_cmd     <= w_data[`DTHA_B_HOME1];
        homing_type2_cmd     <= w_data[`DTHA_B_HOME2];
        virtual_axis_enable  <= w_data[`DTHA_B_VAX];
        position_loop_enable <= w_data[`DTHA_B_LOOPEN];
      end
      if (do_write && aw_addr == `DTHA_A_THA)    compare_threshold_a <= w_data;
      if (do_write && aw_addr == `DTHA_A_THB)    compare_threshold_b <= w_data;
      if (do_write && aw_addr == `DTHA_A_PREF)   position_reference  <= w_data;
      if (do_write && aw_addr == `DTHA_A_HSPD)   homing_speed        <= w_data[15:0];
      if (do_write && aw_addr == `DTHA_A_SPSET)  speed_setpoint      <= w_data[15:0];
      if (do_write && aw_addr == `DTHA_A_PRESET) home_preset_value   <= w_data;
      if (do_write && aw_addr == `DTHA_A_VSPD)   virtual_axis_speed  <= w_data[15:0];
      if (tick) begin
        compare_a_flag <= $signed(compare_threshold_a) >
          $signed(compare_a_source_sel ? position_reference : mpos);
        compare_b_flag <= $signed(compare_threshold_b) >
          $signed(compare_b_source_sel ? position_reference : mpos);
      end
      // set wins over a software clear in the same cycle
      if (cap_rise) begin
        captured_position  <= mpos;
        capture_event_flag <= 1'b1;
      end else if (wr_ctrl && w_data[`DTHA_B_CAPCLR])
        capture_event_flag <= 1'b0;
      if (!home_cmd && hstate != dtha_pkg::DTHA_H_IDLE && !wr_ctrl) begin
        hstate <= dtha_pkg::DTHA_H_IDLE;
      end else if (tick) begin
        case (hstate)
          dtha_pkg::DTHA_H_IDLE: begin
            if (home_cmd) begin
              home_type2 <= homing_type2_cmd;
              position_loop_enable <= 1'b0;
              if (home_sync[1]) begin
                speed_setpoint <= 16'(-homing_speed);
                hstate <= dtha_pkg::DTHA_H_BACKOFF;
              end else begin
                speed_setpoint <= homing_speed;
                hstate <= dtha_pkg::DTHA_H_SEEK;
              end
            end
          end
          dtha_pkg::DTHA_H_BACKOFF: begin
            if (!home_sync[1]) begin
              speed_setpoint <= homing_speed;
              hstate <= dtha_pkg::DTHA_H_SEEK;
            end
          end
          dtha_pkg::DTHA_H_SEEK: begin
            if (home_rise) begin
              speed_setpoint <= 16'h0;
              hold_cnt <= 16'h1;
              hstate <= dtha_pkg::DTHA_H_HOLD;
            end
          end
          dtha_pkg::DTHA_H_HOLD: begin
            hold_cnt <= hold_cnt + 16'h1;
            if (home_end) begin
              position_reference  <= home_type2 ? home_preset_value : 32'h0;
              position_load_value <= home_type2 ? home_preset_value : 32'h0;
              position_load <= 1'b1;
              position_loop_enable <= 1'b1;
              hstate <= dtha_pkg::DTHA_H_DONE;
            end
          end
          dtha_pkg::DTHA_H_DONE: begin
            {homing_type1_cmd, homing_type2_cmd} <= 2'h0;
            hstate <= dtha_pkg::DTHA_H_IDLE;
          end
          default: hstate <= dtha_pkg::DTHA_H_IDLE;
        endcase
      end
    end
  end

  dtha_quad u_quad (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (vax_ok),
    .speed   (virtual_axis_speed),
    .phase_a (encoder_emulation_a),
    .phase_b (encoder_emulation_b)
  );

  // ************************************************
  // checks
  // ************************************************
  AST_CAP_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_rise |=> capture_event_flag && captured_position == $past(mpos)) else $error("capture missed");
  AST_CMP_A: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !compare_a_source_sel && !wr_ctrl |=> compare_a_flag == ($signed($past(compare_threshold_a)) > $signed($past(mpos))))
    else $error("compare a wrong");
  AST_CMP_B: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && compare_b_source_sel && !wr_ctrl |=> compare_b_flag ==
    ($signed($past(compare_threshold_b)) > $signed($past(position_reference)))) else $error("compare b wrong");
  AST_TBL_WR: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && val_dirty && !clear_busy |=> tbl[$past(table_pointer)] == $past(table_value)) else $error("table write lost");
  AST_HOME_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    home_end && !wr_ctrl && home_cmd |=> position_load && position_loop_enable) else $error("homing end wrong");
  AST_HOME_PRESET: assert property (@(posedge aclk) disable iff (!aresetn)
    position_load && home_type2 |-> position_reference == home_preset_value) else $error("preset not loaded");
  AST_ML_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    ml_end && tick_cnt[0] |=> !mode_load_cmd) else $error("mode load stuck");
  AST_VAX_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    !vax_ok [*3] |=> $stable(encoder_emulation_a)) else $error("encoder moves while off");
  COV_CAP: cover property (@(posedge aclk) cap_rise);
  COV_HOME: cover property (@(posedge aclk) position_load);
  COV_ML: cover property (@(posedge aclk) ml_end);
endmodule
`default_nettype wire

// ---- verif/dtha_far.sv ----
// far-side model: motor position source, capture input and homing sensor
`timescale 1ns/1ps
`default_nettype none
// ****
// far side of the position block
// ****
module dtha_far (
  input  wire logic        aclk,
  input  wire logic [31:0] pos_set,
  input  wire logic        pos_set_en,
  input  wire logic        cap_lvl,
  input  wire logic        sens_lvl,
  input  wire logic        position_load,
  input  wire logic [31:0] position_load_value,
  output logic [31:0]      motor_position_in,
  output logic             capture_input,
  output logic             homing_sensor
);
  // home load wins so the loop sees the new origin at once
  always_ff @(posedge aclk) begin
    if (position_load) begin
      motor_position_in <= position_load_value;
    end else if (pos_set_en) begin
      motor_position_in <= pos_set;
    end
    capture_input <= cap_lvl;
    homing_sensor <= sens_lvl;
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for table, compare, capture and homing
`timescale 1ns/1ps
`default_nettype none
`include "dtha_cfg.svh"
// ****
// bench top
// ****
module tb;
  localparam int T = 50;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        position_load, encoder_emulation_a, encoder_emulation_b, capture_input, homing_sensor;
  logic        pos_set_en, cap_lvl, sens_lvl;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, position_load_value, motor_position_in, pos_set, rd;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  axis_config;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          mismatches, checks, seed, i, t, p, v, n;
  longint      per;
  logic        q;
  int          tbl[256];
  dtha_top #(.TICK_CYCLES(T), .HOLD_TICKS(2)) dut (.*);
  dtha_far far (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(e, rd, n);
  endtask
  task automatic tk(input int n);
    repeat (n * T + 5) @(posedge aclk);
  endtask
  // one quadrature step toggles a^b; measure the cycles between two steps
  task automatic vmeas(input int s, input int rpm);
    wr(`DTHA_A_VSPD, 32'(s));
    wr(`DTHA_A_CTRL, 32'h20);
    per = 64'd60000000000 / (`DTHA_CLK_NS * `DTHA_QUAD_STEPS * rpm);
    q = encoder_emulation_a ^ encoder_emulation_b;
    n = 0;
    while ((encoder_emulation_a ^ encoder_emulation_b) == q) @(posedge aclk);
    q = ~q;
    while ((encoder_emulation_a ^ encoder_emulation_b) == q) begin
      @(posedge aclk);
      n++;
    end
    chk(1, 32'(n >= per && n <= per + 1), "vax_period");
    wr(`DTHA_A_CTRL, 0);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    print_verdict();
  end
  initial begin
    seed = 4;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pos_set} = 80'h0;
    {cap_lvl, sens_lvl, pos_set_en} = 3'h1;
    s_axi_wstrb = 4'hF;
    axis_config = 3'h4;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (200) @(posedge aclk);
    rc(8'h00, 0, "ctrl");
    rc(8'h40, 0, "unmapped");
    chk(2, 32'(rs), "rresp");
    wr(8'h40, 32'h0);
    chk(2, 32'(rs), "bresp");
    wr(8'h08, 32'hC8);
    chk(0, 32'(rs), "bresp");
    tk(1);
    rc(8'h0C, 0, "val");
    for (i = 0; i < 4; i++) begin
      p = 64 + ($random(seed) & 8'h7F);
      for (t = 0; t < 2; t++) begin
        v = $random(seed) & 16'hFFFF;
        tbl[p + t] = v;
        wr(8'h08, 32'(p + t));
        tk(1);
        wr(8'h0C, 32'(v));
        tk(1);
      end
      wr(8'h08, 32'(p));
      tk(1);
      rc(8'h0C, 32'(tbl[p]), "val");
      rc(8'h10, 32'(tbl[p + 1]), "next");
    end
    wr(8'h08, 32'hFF);
    tk(1);
    rc(8'h08, 32'hFF, "ptr");
    for (i = 0; i < 18; i++) begin
      tbl[i] = $random(seed) & 16'hFFFF;
      wr(8'h80 + 8'(4 * i), 32'(tbl[i]));
    end
    rc(8'hC4, 32'(tbl[17]), "direct");
    wr(8'h08, 32'h0);
    tk(1);
    wr(8'h00, 32'h10);
    tk(2);
    rc(8'h38, 32'(tbl[0]), "opmode");
    rc(8'h3C, 32'(tbl[1]), "mpar");
    rc(8'h00, 0, "ctrl");
    for (i = 0; i < 4; i++) begin
      v = $random(seed) & 32'h3FFFFFFF;
      pos_set <= 32'(v);
      wr(8'h20, 32'(v + 1));
      wr(8'h14, 32'(v + i - 1));
      wr(8'h18, 32'(v + 2 - i));
      wr(8'h00, 32'(i));
      tk(1);
      t = int'((v + i - 1) > ((i & 1) ? v + 1 : v)) + 2 * int'((v + 2 - i) > ((i & 2) ? v + 1 : v));
      rc(8'h04, 32'(t), "stat");
    end
    cap_lvl <= 1'b1;
    tk(1);
    rc(8'h24, 32'(v), "capt");
    cap_lvl <= 1'b0;
    tk(1);
    rc(8'h04, 32'h5, "stat");
    wr(8'h00, 32'h43);
    tk(1);
    rc(8'h04, 32'h1, "stat");
    pos_set_en <= 1'b0;
    for (t = 0; t < 2; t++) begin
      v = $random(seed) & 16'h7FFF;
      wr(8'h30, 32'(v + 9));
      wr(8'h28, 32'(v));
      sens_lvl <= t[0];
      wr(8'h00, 32'(4 << t));
      tk(2);
      rc(8'h2C, t ? (-v) & 32'hFFFF : 32'(v), "spset");
      sens_lvl <= 1'b0;
      tk(1);
      rc(8'h2C, 32'(v), "spset");
      sens_lvl <= 1'b1;
      tk(1);
      rc(8'h2C, 0, "spset");
      tk(4);
      rc(8'h00, 32'h80, "ctrl");
      rc(8'h1C, t ? 32'(v + 9) : 0, "mpos");
      sens_lvl <= 1'b0;
      wr(8'h00, 0);
      tk(1);
    end
    vmeas(3500, 3500);
    vmeas(-5000, 3500);
    print_verdict();
  end
endmodule
`default_nettype wire
